// [core/dual_rail_sequencer.sv]
// Purpose: Start-up sequencer and fault supervisor for a boost/buck pair.
// Assumes: Comparator inputs synchronous to clk; one bus master.
// Notes: Fault filters and delays count a millisecond time base.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none

module dual_rail_sequencer
    import seq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Enable pin and input power presence
    input wire logic enable_pin,
    input wire logic power_present,
    // Comparator results
    input wire sense_t sense,
    // Power stage commands
    output var drive_t drive,
    output logic rails_good_flag,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ****************************************
    // Declarations
    // ****************************************
    seq_state_t state_q;                // Sequencer state
    logic [TICK_W-1:0] presc_q;         // Time base prescaler
    logic tick_q;                       // One pulse per millisecond
    logic [TMR_W-1:0] tmr_q;            // State timer in ticks
    logic [3:0] cycles_q;               // Fault power cycles
    logic [FLT_W-1:0] flt_cnt_q [NFLT]; // Fault filter counters
    logic [NFLT-1:0] flt_trip;          // Filter tripped
    logic [NFLT-1:0] flt_cond;          // Filter input condition
    logic run_q;                        // Software run enable
    logic [NFLT-1:0] fault_q;           // Sticky fault causes
    logic go;                           // Effective enable
    logic active;                       // A rail is being powered
    logic cycle_fault;                  // Fault that power-cycles
    logic bus_take;                     // Access accepted this edge
    drive_t drive_d;                    // Next stage commands

    // Decode of register reads, used by the read path
    function automatic logic [31:0] reg_read(input logic [3:0] a,
            input seq_state_t s, input logic pg, input logic psm,
            input logic [3:0] cyc, input logic [NFLT-1:0] f,
            input logic run);
        logic [31:0] v;
        // Unmapped offsets read as zero
        v = 32'h0000_0000;
        if (a == REG_CTRL) begin
            v[CTRL_RUN_BIT] = run;
        end else if (a == REG_STATUS) begin
            v[ST_STATE_LSB +: 4] = s;
            v[ST_PG_BIT] = pg;
            v[ST_LATCH_BIT] = (s == S_LATCHED);
            v[ST_PSM_BIT] = psm;
        end else if (a == REG_CYCLES) begin
            v[3:0] = cyc;
        end else if (a == REG_FAULT) begin
            v[NFLT-1:0] = f;
        end
        return v;
    endfunction : reg_read

    // Enable needs pin, power and software run bit
    assign go = enable_pin & power_present & run_q;
    // Stages run only while enabled, so a dropped enable never
    // leaves a stage on while its rail is being discharged
    assign active = go && ((state_q == S_LINEAR) || (state_q == S_FIXED) ||
        (state_q == S_PSKIP) || (state_q == S_BUCK) ||
        (state_q == S_PGWAIT) || (state_q == S_RUN));
    // Faults that power-cycle; a short latches instead
    assign cycle_fault = flt_trip[F_LOWBATT] | flt_trip[F_TOL] |
        flt_trip[F_OVL];

    // ****************************************
    // Time base
    // ****************************************

    // Prescaler makes one tick per millisecond
    // Tick is a one-cycle strobe, never used as a clock
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_q <= '0;
            tick_q <= 1'b0;
        end else if (presc_q == TICK_W'(TICK_CYCLES - 1)) begin
            presc_q <= '0;
            tick_q <= 1'b1;
        end else begin
            presc_q <= presc_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ****************************************
    // Fault filters
    // ****************************************

    // Conditions, each armed only while the rails are powered
    always_comb begin
        flt_cond[F_LOWBATT] = active & ~sense.battery_ok;
        flt_cond[F_TOL] = (state_q == S_RUN) &
            ~(sense.boost_fb_good & sense.buck_fb_good);
        flt_cond[F_OVL] = active & sense.boost_overload;
        flt_cond[F_SHORT] = active & sense.boost_short;
    end

    // One counter per filter, cleared when condition goes away
    for (genvar i = 0; i < NFLT; i++) begin : g_flt
        always_ff @(posedge clk) begin
            if (rst || !flt_cond[i]) begin
                flt_cnt_q[i] <= '0;
            end else if (tick_q && flt_cnt_q[i] != FLT_LIM[i]) begin
                flt_cnt_q[i] <= flt_cnt_q[i] + 1'b1;
            end
        end
        // Tripped while the count sits at its limit
        assign flt_trip[i] = flt_cond[i] && (flt_cnt_q[i] == FLT_LIM[i]);
    end

    // ****************************************
    // Sequencer
    // ****************************************

    // Main state machine with its tick timer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_OFF;
            tmr_q <= '0;
            cycles_q <= '0;
        end else if (!go) begin
            // Enable low or power gone: clear everything
            state_q <= S_OFF;
            tmr_q <= '0;
            cycles_q <= '0;
        end else begin
            case (state_q)
                S_OFF: begin
                    // Enabled: start with the linear high side
                    state_q <= S_LINEAR;
                    tmr_q <= '0;
                end
                S_LINEAR, S_FIXED, S_PSKIP, S_BUCK, S_PGWAIT, S_RUN: begin
                    // A short outranks the retrying faults
                    if (flt_trip[F_SHORT]) begin
                        state_q <= S_LATCHED;
                    end else if (cycle_fault) begin
                        state_q <= S_DISCH;
                        tmr_q <= '0;
                    end else begin
                        case (state_q)
                            S_LINEAR: begin
                                if (sense.boost_at_vin) begin
                                    state_q <= S_FIXED;
                                end
                            end
                            S_FIXED: begin
                                if (sense.boost_above_1v6) begin
                                    state_q <= S_PSKIP;
                                end
                            end
                            S_PSKIP: begin
                                if (sense.boost_near_reg) begin
                                    state_q <= S_BUCK;
                                end
                            end
                            S_BUCK: begin
                                // Buck running, wait for target
                                if (sense.buck_at_target) begin
                                    state_q <= S_PGWAIT;
                                    tmr_q <= '0;
                                end
                            end
                            S_PGWAIT: begin
                                // Turn-on delay while all good
                                if (!(sense.buck_fb_good &&
                                        sense.boost_fb_good &&
                                        sense.battery_ok)) begin
                                    tmr_q <= '0;
                                end else if (tmr_q == PG_ON_TICKS) begin
                                    state_q <= S_RUN;
                                end else if (tick_q) begin
                                    tmr_q <= tmr_q + 1'b1;
                                end
                            end
                            default: begin
                                // Running; filters guard the rails
                                state_q <= S_RUN;
                            end
                        endcase
                    end
                end
                S_DISCH: begin
                    // Rails pulled to ground, then sleep
                    if (tmr_q == DISCH_TICKS) begin
                        state_q <= S_COOL;
                        tmr_q <= '0;
                        cycles_q <= cycles_q + 1'b1;
                    end else if (tick_q) begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                S_COOL: begin
                    // Cool-off, then retry or latch
                    if (tmr_q != COOL_TICKS) begin
                        if (tick_q) begin
                            tmr_q <= tmr_q + 1'b1;
                        end
                    end else if (cycles_q == MAX_CYCLES) begin
                        state_q <= S_LATCHED;
                    end else if (sense.battery_ok) begin
                        state_q <= S_LINEAR;
                        tmr_q <= '0;
                    end
                end
                default: begin
                    // Latched off until enable toggles
                    state_q <= S_LATCHED;
                end
            endcase
        end
    end

    // ****************************************
    // Stage commands
    // ****************************************

    // Combinational next value of the stage commands
    always_comb begin
        drive_d = '0;
        drive_d.boost_en = active;
        drive_d.hs_linear = (state_q == S_LINEAR) ||
            (active && sense.boost_short);
        drive_d.fixed_duty = (state_q == S_FIXED);
        // Short latch holds only while latched off
        drive_d.hs_latched_off = (state_q == S_LATCHED) &&
            drive.hs_latched_off;
        if (active && flt_trip[F_SHORT]) begin
            drive_d.hs_latched_off = 1'b1;
        end
        // Pulse-skip forced during ramp, hysteresis once running
        if (state_q == S_PSKIP || state_q == S_FIXED ||
                state_q == S_LINEAR) begin
            drive_d.pulse_skip_mode = 1'b1;
        end else if (!active) begin
            drive_d.pulse_skip_mode = 1'b1;
        end else if (drive.pulse_skip_mode) begin
            drive_d.pulse_skip_mode = ~sense.load_hi;
        end else begin
            drive_d.pulse_skip_mode = sense.load_lo;
        end
        // Low side off at limit, back on at next switching clock
        if (!active || state_q == S_LINEAR || sense.boost_ls_ilim) begin
            drive_d.boost_ls_on = 1'b0;
        end else if (sense.boost_clk) begin
            drive_d.boost_ls_on = 1'b1;
        end else begin
            drive_d.boost_ls_on = drive.boost_ls_on;
        end
        // High side takes over whenever the low side is off while the boost is active and not latched off
        drive_d.boost_hs_on = active && !drive_d.boost_ls_on &&
            !drive_d.hs_latched_off;
        // Buck runs off the boost rail, so only while it is powered
        drive_d.buck_en = active && ((state_q == S_BUCK) ||
            (state_q == S_PGWAIT) || (state_q == S_RUN));
        // Buck: off at limit, new cycle when output drops
        if (!drive_d.buck_en || sense.buck_ilim) begin
            drive_d.buck_hs_on = 1'b0;
        end else if (sense.buck_below_reg) begin
            drive_d.buck_hs_on = 1'b1;
        end else begin
            drive_d.buck_hs_on = drive.buck_hs_on;
        end
        // Discharge when disabled, off, discharging, cooling off or latched
        drive_d.boost_discharge = !go || state_q == S_OFF ||
            state_q == S_DISCH || state_q == S_COOL ||
            state_q == S_LATCHED;
        drive_d.buck_discharge = drive_d.boost_discharge;
    end

    // Registered stage commands and power-good
    always_ff @(posedge clk) begin
        if (rst) begin
            drive <= '0;
            rails_good_flag <= 1'b0;
        end else begin
            drive <= drive_d;
            // Power-good drops in the same edge a fault trips
            rails_good_flag <= go && (state_q == S_RUN) &&
                !cycle_fault && !flt_trip[F_SHORT];
        end
    end

    // ****************************************
    // Register bus
    // ****************************************

    // Access is taken in the cycle waitrequest is low
    assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;

    // Waitrequest low for one cycle per access, read data with it
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? reg_read(avs_address, state_q,
                rails_good_flag, drive.pulse_skip_mode, cycles_q,
                fault_q, run_q) : 32'h0000_0000;
        end else begin
            // Answer given or idle: back to waiting
            avs_waitrequest <= 1'b1;
        end
    end

    // Control register write
    // Clearing run acts like the enable pin going low
    always_ff @(posedge clk) begin
        if (rst) begin
            run_q <= CTRL_RUN_RST;
        end else if (bus_take && avs_write && avs_address == REG_CTRL) begin
            run_q <= avs_writedata[CTRL_RUN_BIT];
        end
    end

    // Sticky fault causes, write one to clear, new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q <= '0;
        end else begin
            fault_q <= (fault_q & ~((bus_take && avs_write &&
                avs_address == REG_FAULT) ? avs_writedata[NFLT-1:0] :
                {NFLT{1'b0}})) | (flt_trip & {NFLT{active}});
        end
    end

endmodule : dual_rail_sequencer

`default_nettype wire

// [core/seq_pkg.sv]
// Purpose: Shared constants and types for the dual rail sequencer.
// Assumes: 250 MHz clock, slow time base of one tick per millisecond.
// Notes: Times are given in ms, tick counts are derived from them.
`default_nettype none

package seq_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;          // Clock period
    localparam int TICK_NS = 1_000_000;        // Time base period, 1 ms
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 18;                // Prescaler width
    localparam int PG_ON_MS = 20;              // Power-good turn-on delay
    localparam int LOWBATT_MS = 120;           // Low battery filter
    localparam int TOL_MS = 90;                // Rail tolerance deglitch
    localparam int OVL_MS = 90;                // Boost overload filter
    localparam int SHORT_MS = 31;              // Short lasts over 30 ms
    localparam int DISCH_MS = 10;              // Discharge phase length
    localparam int COOL_MS = 1300;             // Cool-off period
    localparam int TMR_W = 11;                 // State timer width
    localparam int FLT_W = 8;                  // Filter counter width
    localparam logic [TMR_W-1:0] PG_ON_TICKS =
        TMR_W'(PG_ON_MS * 1_000_000 / TICK_NS);
    localparam logic [TMR_W-1:0] DISCH_TICKS =
        TMR_W'(DISCH_MS * 1_000_000 / TICK_NS);
    localparam logic [TMR_W-1:0] COOL_TICKS =
        TMR_W'(COOL_MS * 1_000_000 / TICK_NS);
    // Filter limits, one per fault filter
    localparam int NFLT = 4;
    localparam int F_LOWBATT = 0;
    localparam int F_TOL = 1;
    localparam int F_OVL = 2;
    localparam int F_SHORT = 3;
    localparam logic [FLT_W-1:0] FLT_LIM [NFLT] = '{
        FLT_W'(LOWBATT_MS * 1_000_000 / TICK_NS),
        FLT_W'(TOL_MS * 1_000_000 / TICK_NS),
        FLT_W'(OVL_MS * 1_000_000 / TICK_NS),
        FLT_W'(SHORT_MS * 1_000_000 / TICK_NS)};
    localparam logic [3:0] MAX_CYCLES = 4'hF;  // Power cycles before latch-off

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CYCLES = 4'h8;
    localparam logic [3:0] REG_FAULT = 4'hC;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int ST_STATE_LSB = 0;           // Four bits of state
    localparam int ST_PG_BIT = 4;
    localparam int ST_LATCH_BIT = 5;
    localparam int ST_PSM_BIT = 6;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        S_OFF, S_LINEAR, S_FIXED, S_PSKIP, S_BUCK, S_PGWAIT, S_RUN,
        S_DISCH, S_COOL, S_LATCHED
    } seq_state_t;

    // Analog comparator results
    typedef struct packed {
        logic battery_ok;       // battery_input above 0.85V
        logic boost_at_vin;     // boost_output_rail reached battery
        logic boost_above_1v6;  // boost_output_rail above 1.6V
        logic boost_near_reg;   // boost rail at 92.5% of nominal
        logic boost_fb_good;    // boost_feedback_sense over 92.5% ref
        logic buck_fb_good;     // buck_feedback_sense over 92.5% ref
        logic buck_at_target;   // buck_output_rail at programmed value
        logic load_hi;          // boost load reached 90 mA
        logic load_lo;          // boost load fell to 30 mA
        logic boost_short;      // boost rail shorted to ground
        logic boost_overload;   // boost overload condition
        logic boost_ls_ilim;    // low-side switch over current limit
        logic boost_clk;        // boost switching clock pulse
        logic buck_ilim;        // buck inductor at current limit
        logic buck_below_reg;   // buck output below regulated value
    } sense_t;

    // Power stage commands
    typedef struct packed {
        logic boost_en;         // Boost stage enabled
        logic hs_linear;        // High side as current-limited switch
        logic fixed_duty;       // Fixed duty-cycle clock drives boost
        logic pulse_skip_mode;  // Boost in pulse-skip mode
        logic boost_ls_on;      // Boost low-side switch
        logic boost_hs_on;      // Boost high-side switch
        logic hs_latched_off;   // High side latched off by short
        logic buck_en;          // Buck stage enabled
        logic buck_hs_on;       // Buck high-side switch
        logic boost_discharge;  // Boost rail discharge path
        logic buck_discharge;   // Buck rail discharge path
    } drive_t;

endpackage : seq_pkg

`default_nettype wire

// [bench/seq_monitor.sv]
// Purpose: Port assertions for the rail sequencer
// Assumes: One clock, synchronous reset
// Notes: Bound to the design from the bench top
`default_nettype none
module seq_monitor
    import seq_pkg::*;
#(parameter int TICK_CYCLES = TICK_CYCLES_DEF) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and comparators
    input wire logic enable_pin,
    input wire logic power_present,
    input wire sense_t sense,
    // Outputs
    input wire drive_t drive,
    input wire logic rails_good_flag,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Checks
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_go_linear: assert property ($rose(enable_pin) &&
        power_present && !drive.hs_latched_off |-> ##2 drive.hs_linear)
        else $error("start did not enter linear phase");
    chk_buck_late: assert property ($rose(drive.buck_en) |->
        $past(sense.boost_near_reg, 2)) else $error("buck enabled early");
    chk_fixed_late: assert property ($rose(drive.fixed_duty) |->
        $past(sense.boost_at_vin, 2)) else $error("fixed duty early");
    chk_pg_needs_good: assert property ($rose(rails_good_flag) |->
        $past(sense.boost_fb_good && sense.buck_fb_good, 2)
        && $past(sense.battery_ok, 2)) else $error("power good too early");
    chk_off_drains: assert property (!enable_pin [*3] |->
        drive.boost_discharge) else $error("no discharge while off");
    chk_drain_both: assert property (drive.boost_discharge |->
        drive.buck_discharge && !drive.boost_en && !drive.buck_en)
        else $error("discharge while a stage runs");
    chk_short_holds: assert property (drive.hs_latched_off &&
        enable_pin && power_present |=> drive.hs_latched_off &&
        !drive.boost_en) else $error("short latch released");
    chk_ls_limit: assert property (sense.boost_ls_ilim |=>
        !drive.boost_ls_on && drive.boost_hs_on ==
        (drive.boost_en && !drive.hs_latched_off))
        else $error("low side on over limit");
    chk_buck_limit: assert property (sense.buck_ilim |=>
        !drive.buck_hs_on) else $error("buck high side on at limit");
    chk_bus_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");
    cover property ($rose(rails_good_flag));
    cover property ($rose(drive.hs_latched_off));
    cover property ($rose(drive.boost_discharge));
endmodule : seq_monitor
`default_nettype wire

// [bench/rail_model.sv]
// Purpose: Cell and power stage stand-in
// Assumes: Rails ramp one step per clock
// Notes: Bench knobs inject the faults
`default_nettype none
module rail_model
    import seq_pkg::*;
(
    // Clock
    input wire logic clk,
    // Stage commands and fault knobs
    input wire drive_t drive,
    input wire logic [6:0] knob,
    // Comparator results
    output var sense_t sense
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Rails
    // ****************
    logic [3:0] v1_q = 4'h0; // Boost rail level
    logic [3:0] v2_q = 4'h0; // Buck rail level
    logic [1:0] ph_q = 2'h0; // Switching phase
    // Ramp while enabled, drain when discharged
    always_ff @(posedge clk) begin
        ph_q <= ph_q + 2'h1;
        v1_q <= (drive.boost_en && !knob[2] && v1_q != 4'hF) ? v1_q + 4'h1
            : (drive.boost_discharge ? 4'h0 : v1_q);
        v2_q <= (drive.buck_en && v2_q != 4'hF) ? v2_q + 4'h1
            : (drive.buck_discharge ? 4'h0 : v2_q);
    end
    // Comparators; overload only while the boost runs
    always_comb begin
        sense = '{!knob[0], v1_q >= 4'h2, v1_q >= 4'h6, v1_q >= 4'hC,
            v1_q >= 4'hC && !knob[1], v2_q >= 4'hC && !knob[1],
            v2_q == 4'hF, knob[4], knob[5], knob[2],
            knob[3] && drive.boost_en, knob[6], ph_q == 2'h0,
            drive.buck_hs_on && ph_q == 2'h3, v2_q != 4'hF};
    end
endmodule : rail_model
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the rail sequencer
// Assumes: Two clocks per time base tick
// Notes: Bus answer is awaited, never assumed
`default_nettype none
module tb;
    import seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 2; // Clocks per tick
    `define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
        failures++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
    `define WAIT(c, l) begin cnt = 0; while (!(c) && cnt < (l)) begin \
        @(posedge clk); cnt++; end `CHK("wait", 1'b1, cnt < (l)) end
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic pwr = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [6:0] knob = 7'h00; // Fault and load knobs
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] got;
    logic wreq;
    logic pg;
    sense_t sense;
    drive_t drive;
    int failures = 0;
    int n_checks = 0;
    int cnt;
    // ****************
    // Harness
    // ****************
    always #2 clk = ~clk;
    dual_rail_sequencer #(.TICK_CYCLES(TC)) DUT (.clk(clk), .rst(rst),
        .enable_pin(en), .power_present(pwr), .sense(sense), .drive(drive),
        .rails_good_flag(pg), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wreq));
    rail_model PLANT (.clk(clk), .drive(drive), .knob(knob), .sense(sense));
    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        `WAIT(wreq === 1'b0 && cnt > 0, 50)
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // Startup, faults, latch-off, short
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, REG_CTRL, 0); `CHK("ctrl", 32'h0000_0001, got)
        bus(1'b0, 4'h2, 0); `CHK("unmapped", 32'h0000_0000, got)
        en <= 1'b1;
        `WAIT(sense.buck_at_target, 200)
        `WAIT(pg, 100 * TC)
        `CHK("pg delay", 1'b1, cnt >= 10 * TC && cnt <= 50 * TC)
        bus(1'b0, REG_STATUS, 0); `CHK("run", 32'h16, got & 32'h1F)
        knob[6:4] <= 3'b101;
        repeat (3) @(posedge clk);
        `CHK("fixed mode", 1'b0, drive.pulse_skip_mode)
        knob[6:4] <= 3'b000;
        repeat (3) @(posedge clk);
        `CHK("mode hold", 1'b0, drive.pulse_skip_mode)
        knob[5] <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("skip mode", 1'b1, drive.pulse_skip_mode)
        $display("test startup done");
        for (int k = 0; k < 2; k++) begin
            knob[k] <= 1'b1;
            `WAIT(!pg, 200 * TC)
            `CHK("filter", 1'b1, cnt >= (k ? 60 : 100) * TC - 2 &&
                cnt <= (k ? 120 : 150) * TC)
            `WAIT(drive.boost_discharge, 8)
            knob[k] <= 1'b0;
            `WAIT(drive.boost_en, 3000 * TC)
            `CHK("cool", 1'b1, cnt >= 1250 * TC && cnt <= 1400 * TC)
            `WAIT(pg, 300)
            bus(1'b0, REG_FAULT, 0); `CHK("fault", 1'b1, got[k])
            bus(1'b1, REG_FAULT, 32'h0000_000F);
            bus(1'b0, REG_FAULT, 0); `CHK("clear", 32'h0, got)
            bus(1'b0, REG_CYCLES, 0); `CHK("cycles", k + 1, got)
            $display("test fault %0d done", k);
        end
        knob[3] <= 1'b1;
        repeat (13) begin
            `WAIT(drive.boost_en, 3000 * TC)
            `WAIT(drive.boost_discharge, 200 * TC)
        end
        repeat (1400 * TC) @(posedge clk);
        `CHK("latched off", 1'b0, drive.boost_en)
        bus(1'b0, REG_STATUS, 0); `CHK("latch", 32'h29, got & 32'h3F)
        bus(1'b0, REG_CYCLES, 0); `CHK("count", 32'hF, got)
        bus(1'b0, REG_FAULT, 0); `CHK("overload", 32'h4, got)
        knob[3] <= 1'b0;
        en <= 1'b0;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        `WAIT(pg, 300)
        bus(1'b0, REG_CYCLES, 0); `CHK("fresh", 32'h0, got)
        $display("test latch done");
        knob[2] <= 1'b1;
        `WAIT(drive.hs_latched_off, 40 * TC)
        `CHK("short", 1'b1, cnt >= 30 * TC)
        repeat (1500 * TC) @(posedge clk);
        `CHK("no retry", 1'b0, drive.boost_en)
        knob[2] <= 1'b0;
        pwr <= 1'b0;
        repeat (3) @(posedge clk);
        pwr <= 1'b1;
        `WAIT(pg, 300)
        `CHK("unlatched", 1'b0, drive.hs_latched_off)
        bus(1'b1, REG_CTRL, 0);
        @(posedge clk);
        `CHK("drain", 2'b10, {drive.boost_discharge, drive.boost_en})
        $display("test short done");
        stop_test();
    end
    // Hang guard
    initial begin
        repeat (90_000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule : tb
bind dual_rail_sequencer seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.*);
`default_nettype wire
